// ---- verilog/pewc_consts.vh ----
// constants for the parallel eeprom write controller
// Overview of operation
// - host keeps address bits six to fourteen fixed through a page load
// - host starts each next byte load within 50 us of previous one
// - host writes three command bytes before data while protected
// - host always follows an unlock sequence with a data write
// - a six-write sequence clears protection after one write cycle time
// - host issues each command sequence without intervening accesses
`ifndef PEWC_CONSTS_VH
`define PEWC_CONSTS_VH
`define PEWC_CLK_NS 8
`define PEWC_STROBE_NS 100
`define PEWC_STROBE_CYC ((`PEWC_STROBE_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
`define PEWC_SETUP_NS 40
`define PEWC_SETUP_CYC ((`PEWC_SETUP_NS + `PEWC_CLK_NS - 1) / `PEWC_CLK_NS)
`define PEWC_LOAD_US 100
`define PEWC_LOAD_CYC ((`PEWC_LOAD_US * 1000) / `PEWC_CLK_NS)
`define PEWC_GAP_US 50
`define PEWC_GAP_CYC ((`PEWC_GAP_US * 1000) / `PEWC_CLK_NS)
`define PEWC_WC_MS 10
`define PEWC_WC_CYC ((`PEWC_WC_MS * 1000000) / `PEWC_CLK_NS)
`define PEWC_PAGE_MAX 64
`define PEWC_DQ7_BIT 7
`define PEWC_DQ6_BIT 6
`define PEWC_CMD_NONE 2'h0
`define PEWC_CMD_READ 2'h1
`define PEWC_CMD_WRITE 2'h2
`define PEWC_CMD_POLL 2'h3
`endif

// ---- verilog/pewc_cycle.v ----
// one strobed bus cycle on the memory pins
`timescale 1ns/100ps
module pewc_cycle #(
	parameter STROBE_CYC = 13,
	parameter SETUP_CYC = 5
) (
	input wire clk,
	input wire nrst,
	// request
	input wire go,
	input wire is_write,
	input wire [14:0] addr,
	input wire [7:0] wdata,
	output wire idle,
	output reg done,
	output reg [7:0] rdata,
	// pins
	output reg [14:0] pin_addr,
	output reg pin_sel_n,
	output reg pin_gate_n,
	output reg pin_wr_n,
	output reg [7:0] pin_dq_out,
	output reg pin_dq_oe,
	input wire [7:0] pin_dq_in
);
	localparam S_IDLE = 2'h0;
	localparam S_SETUP = 2'h1;
	localparam S_STROBE = 2'h2;
	localparam S_HOLD = 2'h3;
	reg [1:0] state;
	reg [7:0] cnt;
	reg wr;
	reg [7:0] dq_s1;
	reg [7:0] dq_s2;
	assign idle = (state == S_IDLE);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= pin_dq_in;
			dq_s2 <= dq_s1;
		end
	end
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			cnt <= 8'h00;
			wr <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
			pin_addr <= 15'h0000;
			pin_sel_n <= 1'b1;
			pin_gate_n <= 1'b1;
			pin_wr_n <= 1'b1;
			pin_dq_out <= 8'h00;
			pin_dq_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
			S_IDLE: begin
				if (go) begin
					// address settles before select falls
					pin_addr <= addr;
					pin_dq_out <= wdata;
					wr <= is_write;
					pin_dq_oe <= is_write;
					pin_gate_n <= 1'b1;
					cnt <= SETUP_CYC[7:0];
					state <= S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt == 8'h00) begin
					pin_sel_n <= 1'b0;
					if (wr)
						pin_wr_n <= 1'b0;
					else
						pin_gate_n <= 1'b0;
					cnt <= STROBE_CYC[7:0];
					state <= S_STROBE;
				end else
					cnt <= cnt - 8'h01;
			end
			S_STROBE: begin
				if (cnt == 8'h00) begin
					// read data waited through the two-stage sync
					if (!wr)
						rdata <= dq_s2;
					pin_wr_n <= 1'b1;
					pin_gate_n <= 1'b1;
					pin_sel_n <= 1'b1;
					cnt <= SETUP_CYC[7:0];
					state <= S_HOLD;
				end else
					cnt <= cnt - 8'h01;
			end
			S_HOLD: begin
				// data held past rising strobe, then bus released
				if (cnt == 8'h00) begin
					pin_dq_oe <= 1'b0;
					done <= 1'b1;
					state <= S_IDLE;
				end else
					cnt <= cnt - 8'h01;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // pewc_cycle

// ---- verilog/pewc_ctrl.v ----
// host controller for a byte-wide self-timed eeprom
`timescale 1ns/100ps
`include "pewc_consts.vh"
module pewc_ctrl #(
	parameter LOAD_CYC = `PEWC_LOAD_CYC,
	parameter GAP_CYC = `PEWC_GAP_CYC,
	parameter WC_CYC = `PEWC_WC_CYC,
	parameter PROTECT = 1'b0,
	parameter [14:0] CMD_ADDR1 = 15'h5555,
	parameter [14:0] CMD_ADDR2 = 15'h2AAA,
	parameter [7:0] CMD_DATA1 = 8'hAA,
	parameter [7:0] CMD_DATA2 = 8'h55,
	parameter [7:0] CMD_LOCK = 8'hA0,
	parameter [7:0] CMD_DIS1 = 8'h80,
	parameter [7:0] CMD_DIS2 = 8'h20
) (
	// clock and reset
	input wire CLK,
	input wire NRST,
	// user request
	input wire [1:0] CMD,
	input wire [14:0] ADDR,
	input wire [7:0] WDATA,
	input wire LAST,
	input wire UNPROTECT,
	output wire READY,
	output reg DONE,
	output reg [7:0] RDATA,
	output reg BUSY,
	output reg TIMEOUT,
	output reg PAGE_ERR,
	// memory pins
	output wire [14:0] WORD_ADDRESS_LINES,
	output wire CHIP_SELECT_N,
	output wire OUTPUT_GATE_N,
	output wire WRITE_STROBE_N,
	output wire [7:0] BYTE_DATA_LINES_OUT,
	output wire BYTE_DATA_LINES_OE,
	input wire [7:0] BYTE_DATA_LINES_IN
);
	localparam S_IDLE = 3'h0;
	localparam S_PRE = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_GAP = 3'h3;
	localparam S_POLL = 3'h4;
	localparam S_READ = 3'h5;
	localparam S_DIS = 3'h6;
	reg [2:0] state;
	reg [2:0] pre_idx;
	reg [2:0] pre_len;
	reg [6:0] page_cnt;
	reg [8:0] page_base;
	reg [7:0] last_data;
	reg [14:0] last_addr;
	reg [31:0] tmr;
	reg [31:0] wc_tmr;
	reg first_poll;
	reg [7:0] prev_poll;
	reg cyc_go;
	reg cyc_wr;
	reg [14:0] cyc_addr;
	reg [7:0] cyc_wdata;
	wire cyc_idle;
	wire cyc_done;
	wire [7:0] cyc_rdata;
	reg [14:0] seq_addr;
	reg [7:0] seq_data;
	// command sequence step table
	always @* begin
		seq_addr = CMD_ADDR1;
		seq_data = CMD_DATA1;
		case (pre_idx)
		3'h0: begin seq_addr = CMD_ADDR1; seq_data = CMD_DATA1; end
		3'h1: begin seq_addr = CMD_ADDR2; seq_data = CMD_DATA2; end
		3'h2: begin seq_addr = CMD_ADDR1; seq_data = CMD_DIS1; end
		3'h3: begin seq_addr = CMD_ADDR1; seq_data = CMD_DATA1; end
		3'h4: begin seq_addr = CMD_ADDR2; seq_data = CMD_DATA2; end
		3'h5: begin seq_addr = CMD_ADDR1; seq_data = CMD_DIS2; end
		default: begin seq_addr = CMD_ADDR1; seq_data = CMD_DATA1; end
		endcase
		if (pre_len == 3'h3 && pre_idx == 3'h2)
			seq_data = CMD_LOCK;
	end
	pewc_cycle #(
		.STROBE_CYC(`PEWC_STROBE_CYC),
		.SETUP_CYC(`PEWC_SETUP_CYC)
	) u_cycle (
		.clk(CLK),
		.nrst(NRST),
		.go(cyc_go),
		.is_write(cyc_wr),
		.addr(cyc_addr),
		.wdata(cyc_wdata),
		.idle(cyc_idle),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.pin_addr(WORD_ADDRESS_LINES),
		.pin_sel_n(CHIP_SELECT_N),
		.pin_gate_n(OUTPUT_GATE_N),
		.pin_wr_n(WRITE_STROBE_N),
		.pin_dq_out(BYTE_DATA_LINES_OUT),
		.pin_dq_oe(BYTE_DATA_LINES_OE),
		.pin_dq_in(BYTE_DATA_LINES_IN)
	);
	// a request is taken only in idle or in the byte load gap, with no bus cycle in flight
	assign READY = (state == S_IDLE || state == S_GAP) && cyc_idle && !cyc_go;
	always @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state <= S_IDLE;
			pre_idx <= 3'h0;
			pre_len <= 3'h0;
			page_cnt <= 7'h00;
			page_base <= 9'h000;
			last_data <= 8'h00;
			last_addr <= 15'h0000;
			tmr <= 32'h0;
			wc_tmr <= 32'h0;
			first_poll <= 1'b0;
			prev_poll <= 8'h00;
			cyc_go <= 1'b0;
			cyc_wr <= 1'b0;
			cyc_addr <= 15'h0000;
			cyc_wdata <= 8'h00;
			DONE <= 1'b0;
			RDATA <= 8'h00;
			BUSY <= 1'b0;
			TIMEOUT <= 1'b0;
			PAGE_ERR <= 1'b0;
		end else begin
			cyc_go <= 1'b0;
			DONE <= 1'b0;
			if (state == S_GAP || state == S_POLL)
				tmr <= tmr + 32'h1;
			case (state)
			S_IDLE: begin
				if (UNPROTECT) begin
					pre_idx <= 3'h0;
					pre_len <= 3'h6;
					TIMEOUT <= 1'b0;
					BUSY <= 1'b1;
					state <= S_DIS;
				end else if (CMD == `PEWC_CMD_READ || CMD == `PEWC_CMD_POLL) begin
					cyc_go <= 1'b1;
					cyc_wr <= 1'b0;
					cyc_addr <= ADDR;
					state <= S_READ;
				end else if (CMD == `PEWC_CMD_WRITE) begin
					page_base <= ADDR[14:6];
					page_cnt <= 7'h00;
					PAGE_ERR <= 1'b0;
					TIMEOUT <= 1'b0;
					last_addr <= ADDR;
					last_data <= WDATA;
					BUSY <= 1'b1;
					pre_idx <= 3'h0;
					pre_len <= PROTECT ? 3'h3 : 3'h0;
					state <= PROTECT ? S_PRE : S_DATA;
				end
			end
			S_PRE, S_DIS: begin
				if (cyc_idle && !cyc_go) begin
					if (pre_idx == pre_len) begin
						if (state == S_DIS) begin
							// poll until the toggle bit settles, at most one write cycle time
							// first read only seeds the toggle compare
							tmr <= 32'h0;
							first_poll <= 1'b1;
							wc_tmr <= 32'h0;
							state <= S_POLL;
						end else
							state <= S_DATA;
					end else begin
						// back to back, no other access
						cyc_go <= 1'b1;
						cyc_wr <= 1'b1;
						cyc_addr <= seq_addr;
						cyc_wdata <= seq_data;
						pre_idx <= pre_idx + 3'h1;
					end
				end
			end
			S_DATA: begin
				if (cyc_idle && !cyc_go) begin
					cyc_go <= 1'b1;
					cyc_wr <= 1'b1;
					cyc_addr <= last_addr;
					cyc_wdata <= last_data;
					page_cnt <= page_cnt + 7'h01;
					tmr <= 32'h0;
					state <= S_GAP;
				end
			end
			S_GAP: begin
				// next strobe falls within the byte load window
				if (cyc_idle && !cyc_go && CMD == `PEWC_CMD_WRITE && !LAST
				    && page_cnt < `PEWC_PAGE_MAX && tmr < GAP_CYC) begin
					if (ADDR[14:6] != page_base)
						PAGE_ERR <= 1'b1;
					else begin
						last_addr <= ADDR;
						last_data <= WDATA;
						state <= S_DATA;
					end
				end else if (cyc_idle && !cyc_go && (LAST || tmr >= GAP_CYC
				    || page_cnt == `PEWC_PAGE_MAX)) begin
					// silence past the window starts programming
					tmr <= 32'h0;
					// a stale count would cut the next timeout short
					wc_tmr <= 32'h0;
					first_poll <= 1'b1;
					state <= S_POLL;
				end
			end
			S_POLL: begin
				if (tmr > LOAD_CYC && cyc_idle && !cyc_go) begin
					cyc_go <= 1'b1;
					cyc_wr <= 1'b0;
					cyc_addr <= last_addr;
				end
				if (cyc_done) begin
					prev_poll <= cyc_rdata;
					first_poll <= 1'b0;
					if (!first_poll
					    && cyc_rdata[`PEWC_DQ6_BIT] == prev_poll[`PEWC_DQ6_BIT]
					    && (pre_len == 3'h6 || cyc_rdata[`PEWC_DQ7_BIT]
					    == last_data[`PEWC_DQ7_BIT])) begin
						BUSY <= 1'b0;
						DONE <= 1'b1;
						state <= S_IDLE;
					end
				end
				wc_tmr <= wc_tmr + 32'h1;
				if (wc_tmr >= WC_CYC) begin
					TIMEOUT <= 1'b1;
					BUSY <= 1'b0;
					DONE <= 1'b1;
					state <= S_IDLE;
				end
			end
			S_READ: begin
				if (cyc_done) begin
					RDATA <= cyc_rdata;
					DONE <= 1'b1;
					state <= S_IDLE;
				end
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // pewc_ctrl

// ---- tb/pewc_checker.sv ----
// pin protocol assertions for the eeprom host controller
`timescale 1ns/100ps
module pewc_checker (
	// clock and reset
	input wire CLK,
	input wire NRST,
	// watched pins
	input wire [14:0] WORD_ADDRESS_LINES,
	input wire CHIP_SELECT_N,
	input wire OUTPUT_GATE_N,
	input wire WRITE_STROBE_N,
	input wire [7:0] BYTE_DATA_LINES_OUT,
	input wire BYTE_DATA_LINES_OE,
	input wire DONE
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	property p_gate; BYTE_DATA_LINES_OE |-> OUTPUT_GATE_N; endproperty
	a_gate: assert property (p_gate) else $error("drive in read");
	property p_rd; !OUTPUT_GATE_N |-> !CHIP_SELECT_N && WRITE_STROBE_N;
	endproperty
	a_rd: assert property (p_rd) else $error("bad read pins");
	property p_wr; !WRITE_STROBE_N |-> !CHIP_SELECT_N && BYTE_DATA_LINES_OE
		&& OUTPUT_GATE_N; endproperty
	a_wr: assert property (p_wr) else $error("bad write pins");
	property p_adr; !WRITE_STROBE_N && !$past(WRITE_STROBE_N)
		|-> $stable(WORD_ADDRESS_LINES); endproperty
	a_adr: assert property (p_adr) else $error("addr moved");
	property p_dat; $rose(WRITE_STROBE_N) |-> $stable(BYTE_DATA_LINES_OUT)
		&& BYTE_DATA_LINES_OE; endproperty
	a_dat: assert property (p_dat) else $error("data moved");
	property p_wid; $fell(WRITE_STROBE_N) |-> (!WRITE_STROBE_N)[*8];
	endproperty
	a_wid: assert property (p_wid) else $error("short strobe");
	property p_turn; $rose(OUTPUT_GATE_N) |=> !BYTE_DATA_LINES_OE;
	endproperty
	a_turn: assert property (p_turn) else $error("no turnaround");
	property p_done; DONE |=> !DONE; endproperty
	a_done: assert property (p_done) else $error("long done");
endmodule // pewc_checker
bind pewc_ctrl pewc_checker i_pewc_checker (.CLK(CLK), .NRST(NRST),
	.WORD_ADDRESS_LINES(WORD_ADDRESS_LINES),
	.CHIP_SELECT_N(CHIP_SELECT_N), .OUTPUT_GATE_N(OUTPUT_GATE_N),
	.WRITE_STROBE_N(WRITE_STROBE_N),
	.BYTE_DATA_LINES_OUT(BYTE_DATA_LINES_OUT),
	.BYTE_DATA_LINES_OE(BYTE_DATA_LINES_OE), .DONE(DONE));

// ---- tb/pewc_eeprom_model.sv ----
// behavioural model of the byte-wide eeprom
`timescale 1ns/100ps
module pewc_eeprom_model #(
	parameter [14:0] A1 = 15'h5555,
	parameter [14:0] A2 = 15'h2AAA,
	parameter LOAD_NS = 400,
	parameter PROG_NS = 2000
) (
	// pins
	input wire [14:0] a,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire [7:0] d,
	output wire [7:0] q
);
	reg [7:0] mem [0:32767];
	reg [7:0] rd = 8'h00;
	reg [14:0] la = 15'h0000;
	reg [14:0] lst = 15'h0000;
	reg prot = 1'b0;
	reg unl = 1'b0;
	reg dis = 1'b0;
	reg ld = 1'b0;
	reg busy = 1'b0;
	reg tog = 1'b0;
	integer st = 0;
	integer n = 0;
	time tf = 0;
	time tl = 0;
	wire wr = !ce_n && !we_n && oe_n;
	wire rs = !ce_n && !oe_n;
	// released lines show the inverse so a stale byte cannot pass
	assign q = rs ? rd : ~rd;
	function ok(input integer s);
		case (s)
			0, 3: ok = la == A1 && d == 8'hAA;
			1, 4: ok = la == A2 && d == 8'h55;
			2: ok = la == A1 && d == 8'h80;
			default: ok = 1'b0;
		endcase
	endfunction
	always @(posedge wr) begin
		la = a;
		tf = $time;
	end
	always @(negedge wr) if (!busy && $time - tf >= 20) begin
		if (st == 2 && la == A1 && d == 8'hA0) begin
			unl = 1'b1;
			st = 0;
		end else if (st == 5 && la == A1 && d == 8'h20) begin
			dis = 1'b1;
			ld = 1'b1;
			tl = $time;
			st = 0;
		end else begin
			st = ok(st) ? st + 1 : 0;
			if ((!prot || unl) && n < 64) begin
				mem[la] = d;
				lst = la;
				ld = 1'b1;
				n = n + 1;
				tl = $time;
			end
		end
	end
	always @(posedge rs) begin
		if (busy || ld) begin
			rd = {~mem[lst][7], tog, mem[lst][5:0]};
			tog = ~tog;
		end else
			rd = mem[a];
	end
	initial forever begin
		#10;
		if (ld && $time - tl >= LOAD_NS) begin
			ld = 1'b0;
			busy = 1'b1;
			n = 0;
			#PROG_NS;
			busy = 1'b0;
			if (unl) prot = 1'b1;
			if (dis) prot = 1'b0;
			unl = 1'b0;
			dis = 1'b0;
		end
	end
endmodule // pewc_eeprom_model

// ---- tb/pewc_tb_top.sv ----
// self-checking bench for the eeprom host controller
`timescale 1ns/100ps
module parallel_eeprom_write_control_tb_top;
	reg CLK = 1'b0;
	reg NRST = 1'b0;
	reg [1:0] CMD = 2'h0;
	reg [14:0] ADDR = 15'h0000;
	reg [7:0] WDATA = 8'h00;
	reg LAST = 1'b0;
	reg UNPROTECT = 1'b0;
	wire READY, DONE, BUSY, TIMEOUT, PAGE_ERR, sel_n, gate_n, wr_n, dq_oe;
	wire [7:0] RDATA, dq_out, dq_in, dev_q;
	wire [14:0] wal;
	integer error_cnt = 0;
	integer samples_checked = 0;
	integer i;
	assign dq_in = dq_oe ? dq_out : dev_q;
	// byte window outlasts one strobed cycle; the device window is longer
	pewc_ctrl #(.LOAD_CYC(20), .GAP_CYC(100), .WC_CYC(2000),
		.PROTECT(1'b1)) i_pewc_ctrl (.CLK(CLK), .NRST(NRST), .CMD(CMD),
		.ADDR(ADDR), .WDATA(WDATA), .LAST(LAST), .UNPROTECT(UNPROTECT),
		.READY(READY), .DONE(DONE), .RDATA(RDATA), .BUSY(BUSY),
		.TIMEOUT(TIMEOUT), .PAGE_ERR(PAGE_ERR), .WORD_ADDRESS_LINES(wal),
		.CHIP_SELECT_N(sel_n), .OUTPUT_GATE_N(gate_n),
		.WRITE_STROBE_N(wr_n), .BYTE_DATA_LINES_OUT(dq_out),
		.BYTE_DATA_LINES_OE(dq_oe), .BYTE_DATA_LINES_IN(dq_in));
	pewc_eeprom_model #(.LOAD_NS(2000)) i_pewc_eeprom_model (.a(wal),
		.ce_n(sel_n), .oe_n(gate_n), .we_n(wr_n), .d(dq_out), .q(dev_q));
	initial forever #4 CLK = ~CLK;
	task chk(input string nm, input [14:0] s, input [14:0] e);
		samples_checked = samples_checked + 1;
		if (s !== e) begin
			error_cnt = error_cnt + 1;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task req(input [1:0] c, input [14:0] ad, input [7:0] wd, input l);
		integer n;
		// fresh edge so back-to-back calls never re-drive in one step
		@(posedge CLK) #1;
		CMD = c;
		ADDR = ad;
		WDATA = wd;
		LAST = l;
		n = 0;
		while (READY !== 1'b1 && n < 5000) begin
			@(posedge CLK) #1;
			n = n + 1;
		end
		chk("ready", READY, 1);
		@(posedge CLK) #1;
		CMD = 2'h0;
		LAST = 1'b0;
	endtask
	task wait_done;
		integer n;
		n = 0;
		while (DONE !== 1'b1 && n < 20000) begin
			@(posedge CLK) #1;
			n = n + 1;
		end
		chk("done", DONE, 1);
	endtask
	task t_byte;
		req(2'h2, 15'h0123, 8'h3C, 1'b1);
		wait_done;
		chk("prot", i_pewc_eeprom_model.prot, 1);
		chk("busy", BUSY, 0);
		chk("timeout", TIMEOUT, 0);
		req(2'h1, 15'h0123, 8'h00, 1'b0);
		wait_done;
		chk("rdata", RDATA, 8'h3C);
		req(2'h3, 15'h0123, 8'h00, 1'b0);
		wait_done;
		chk("poll", RDATA, 8'h3C);
	endtask
	task t_page;
		for (i = 0; i < 4; i = i + 1)
			req(2'h2, 15'h0200 + i, 8'hC3 ^ i, 1'b0);
		// close the page by the LAST flag, with no further strobe, rather than by silence
		req(2'h0, 15'h0000, 8'h00, 1'b1);
		wait_done;
		chk("prot", i_pewc_eeprom_model.prot, 1);
		for (i = 0; i < 4; i = i + 1) begin
			req(2'h1, 15'h0200 + i, 8'h00, 1'b0);
			wait_done;
			chk("page", RDATA, 8'hC3 ^ i);
		end
	endtask
	task t_unprot;
		UNPROTECT = 1'b1;
		@(posedge CLK) #1;
		UNPROTECT = 1'b0;
		wait_done;
		chk("prot", i_pewc_eeprom_model.prot, 0);
	endtask
	task t_page_err;
		req(2'h2, 15'h0300, 8'h11, 1'b0);
		@(posedge CLK) #1;
		CMD = 2'h2;
		ADDR = 15'h0340;
		for (i = 0; i < 400 && PAGE_ERR !== 1'b1; i = i + 1)
			@(posedge CLK) #1;
		chk("page_err", PAGE_ERR, 1);
		CMD = 2'h0;
		wait_done;
		chk("page_lst", i_pewc_eeprom_model.lst, 15'h0300);
	endtask
	task results;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge CLK);
		#1 NRST = 1'b1;
		chk("sel_n", sel_n, 1);
		chk("wr_n", wr_n, 1);
		chk("dq_oe", dq_oe, 0);
		chk("prot", i_pewc_eeprom_model.prot, 0);
		t_byte;
		t_page;
		t_unprot;
		t_page_err;
		results;
	end
	// the whole run ends far inside fifty thousand cycles
	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		results;
	end
endmodule // parallel_eeprom_write_control_tb_top
